// >>> src/tase_pkg.sv
// Package for the trap and abort syndrome encoder.
// Assumes a single core clock domain; shared by the encoder and its bench.
package tase_pkg;
    // Exception class codes
    localparam logic [5:0] TASE_EC_SYSREG   = 6'h18;  // 0b011000
    localparam logic [5:0] TASE_EC_IABT_LO  = 6'h20;
    localparam logic [5:0] TASE_EC_IABT_CUR = 6'h21;
    localparam logic [5:0] TASE_EC_IMPDEF   = 6'h1F;
    // Fault code for sync external abort not on a walk
    localparam logic [5:0] TASE_FC_SYNC_EXT = 6'h10;
    // Error type encodings
    localparam logic [1:0] TASE_SET_UER     = 2'h0;
    localparam logic [1:0] TASE_SET_UC      = 2'h2;
    localparam logic [1:0] TASE_SET_UEO     = 2'h3;
    // Syndrome field positions
    localparam int TASE_DIR_BIT   = 0;
    localparam int TASE_CRM_LO    = 1;
    localparam int TASE_RT_LO     = 5;
    localparam int TASE_CRN_LO    = 10;
    localparam int TASE_OP1_LO    = 14;
    localparam int TASE_OP2_LO    = 17;
    localparam int TASE_OP0_LO    = 20;
    localparam int TASE_STAGE1_WALK_FAULT_BIT = 7;
    localparam int TASE_EA_BIT    = 9;
    localparam int TASE_FNV_BIT   = 10;
    localparam int TASE_SET_LO    = 11;
    // Register map
    localparam logic [3:0] TASE_OFF_KCTL   = 4'h0;  // kernel_sys_control_reg trap bits
    localparam logic [3:0] TASE_OFF_HCFG   = 4'h1;  // hyp_config_reg trap bits
    localparam logic [3:0] TASE_OFF_MON    = 4'h2;  // secure/monitor debug config bits
    localparam logic [3:0] TASE_OFF_FRD    = 4'h3;  // fine_read_trap_reg
    localparam logic [3:0] TASE_OFF_FWR    = 4'h4;  // fine_write_trap_reg
    localparam logic [3:0] TASE_OFF_SYND   = 4'h5;  // last syndrome + class
    localparam logic [3:0] TASE_OFF_STAT   = 4'h6;  // last target level, count
    localparam logic [31:0] TASE_CFG_RESET = 32'h0000_0000;

    // Target levels
    typedef enum logic [1:0] {
        TASE_LVL_NONE = 2'b00,
        TASE_LVL_KERN = 2'b01,
        TASE_LVL_HYP  = 2'b10,
        TASE_LVL_MON  = 2'b11
    } tase_level_type;

    // Kinds of system access the pipeline reports
    typedef enum logic [2:0] {
        TASE_ACC_CACHE_MAINT = 3'b000,
        TASE_ACC_CACHE_TYPE  = 3'b001,
        TASE_ACC_ZERO_BLOCK  = 3'b010,
        TASE_ACC_INT_MASK    = 3'b011,
        TASE_ACC_TLB_MAINT   = 3'b100,
        TASE_ACC_ID_GROUP    = 3'b101,
        TASE_ACC_DEBUG       = 3'b110,
        TASE_ACC_FINE_REG    = 3'b111
    } tase_acc_type;

    // Issued system-register transfer from the pipeline
    typedef struct packed {
        logic         valid;
        logic [1:0]   cur_level;     // 0 user,1 kernel,2 hyp,3 monitor
        tase_acc_type kind;
        logic [1:0]   id_group;      // 1..3 for ID-group accesses
        logic [4:0]   fine_index;    // selects a bit of the fine trap registers
        logic         cache_ctl;     // enhanced cache-control operation
        logic [1:0]   op0;
        logic [2:0]   op2;
        logic [2:0]   op1;
        logic [3:0]   major_sysreg_field;
        logic [4:0]   rt;
        logic [3:0]   minor_sysreg_field;
        logic         is_read;
    } tase_sysreq_type;

    // Instruction abort report from the fetch side
    typedef struct packed {
        logic       valid;
        logic       from_lower;
        logic [5:0] fault_code;
        logic [1:0] err_state;
        logic       addr_unknown;
        logic       is_external;
        logic       ext_class;
        logic       stage2;
        logic       s1_walk;
    } tase_abort_type;

    // Implementation-defined exception to the monitor level
    typedef struct packed {
        logic        valid;
        logic [24:0] detail;
    } tase_impdef_type;

    // Recorded syndrome
    typedef struct packed {
        logic [5:0]  exception_class;
        logic [24:0] syndrome_detail;
    } tase_synd_type;
endpackage

// >>> src/tase_encoder.sv
// Trap and abort syndrome encoder: decides system-register traps, builds the
// 25-bit syndrome detail and class, and records them in one cycle.
// Assumes pipeline inputs are synchronous to core_clk; several valid events resolve by priority.
// Function
// RQ1: Trapped transfer puts its general register number in bits 9:5.
// RQ2: Trapped transfer copies the minor register-select field into bits 4:1.
// RQ3: Bit 0 is 0 for a trapped write, 1 for a trapped read.
// RQ4: Syndrome fields are not initialised by reset.
// RQ5: System-register and system-instruction traps use class 0b011000.
// RQ6: Kernel control bits trap user cache, cache-type, zero-block, mask accesses.
// RQ7: Hypervisor TLB trap bit traps lower-level TLB maintenance to hypervisor.
// RQ8: Hypervisor ID-group bits trap ID group 1, 2, 3 accesses.
// RQ9: Monitor debug trap bit sends lower-level debug accesses to monitor.
// RQ10: Hypervisor fine-trap register accesses go to monitor unless allowed.
// RQ11: Separate fine read and write trap registers select trapped accesses.
// RQ12: Enhanced trap feature adds hypervisor cache-control traps, same class.
// RQ13: Implementation-defined monitor exception may fill all of bits 24:0.
// RQ14: Abort zeroes bits 24:13 and 8, places fields at 12:11,10,9,7.
// RQ15: With reliability extension and code 0x10, error state 00, 10, 11.
// RQ16: Error type is zero for other codes or without reliability extension.
// RQ17: Sync external abort sets bit 10 when the fault address is unknown.
// RQ18: Bit 9 classifies external aborts and is zero for others.
// RQ19: Bit 7 marks stage 2 fault on stage 1 walk, else zero.
// RQ20: Transfer copies register-space selector to 21:20 and major field 13:10.
// RQ21: Fault code 0b010000 means sync external abort not on a walk.
// RQ22: Class and detail are written together in the cycle of the exception.
`timescale 1ns/1ps
module tase_encoder #(
    parameter bit RELIABILITY_EXT = 1'b1,
    parameter bit FINE_GRAIN_EXT  = 1'b1,
    parameter bit ENH_VIRT_EXT    = 1'b1
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    // Pipeline events
    input  wire tase_pkg::tase_sysreq_type sysreq,
    input  wire tase_pkg::tase_abort_type  abort_in,
    input  wire tase_pkg::tase_impdef_type impdef_in,
    // Register port
    input  wire logic [3:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [31:0]                    reg_rdata,
    // Exception outputs
    output logic                           exc_taken,
    output tase_pkg::tase_level_type       exc_level,
    output tase_pkg::tase_synd_type        synd_out
);
    import tase_pkg::*;

    // Configuration registers
    logic [31:0]    kctl_reg;   // [0] cache maint,[1] cache type,[2] zero,[3] mask
    logic [31:0]    hcfg_reg;   // [0] tlb,[3:1] id groups,[4] cache ctl
    logic [31:0]    mon_reg;    // [0] debug trap,[1] fine_trap_allow
    logic [31:0]    frd_reg;
    logic [31:0]    fwr_reg;
    logic [7:0]     count_reg;
    tase_synd_type  synd_next;
    tase_level_type lvl_next;
    logic           take_next;

    // Software writes; only these steer the trap decision
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            kctl_reg <= TASE_CFG_RESET;
            hcfg_reg <= TASE_CFG_RESET;
            mon_reg  <= TASE_CFG_RESET;
            frd_reg  <= TASE_CFG_RESET;
            fwr_reg  <= TASE_CFG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                TASE_OFF_KCTL: kctl_reg <= reg_wdata;
                TASE_OFF_HCFG: hcfg_reg <= reg_wdata;
                TASE_OFF_MON:  mon_reg  <= reg_wdata;
                TASE_OFF_FRD:  frd_reg  <= reg_wdata;
                TASE_OFF_FWR:  fwr_reg  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Trap decision for system-register transfers
    function automatic tase_level_type trap_level(input tase_sysreq_type r);
        tase_level_type l;
        logic           user;
        logic           lower;
        l     = TASE_LVL_NONE;
        user  = (r.cur_level == 2'd0);
        lower = (r.cur_level < 2'd2);
        case (r.kind)
            TASE_ACC_CACHE_MAINT, TASE_ACC_CACHE_TYPE,
            TASE_ACC_ZERO_BLOCK, TASE_ACC_INT_MASK: begin
                // Kernel controls act on user-level code only [RQ6]
                if (user && kctl_reg[r.kind[1:0]]) begin
                    l = TASE_LVL_KERN;
                end
                if (ENH_VIRT_EXT && lower && r.cache_ctl && hcfg_reg[4]) begin
                    l = TASE_LVL_HYP;  // [RQ12]
                end
            end
            TASE_ACC_TLB_MAINT: begin
                if (lower && hcfg_reg[0]) begin
                    l = TASE_LVL_HYP;  // [RQ7]
                end
                if (ENH_VIRT_EXT && lower && r.cache_ctl && hcfg_reg[4]) begin
                    l = TASE_LVL_HYP;  // [RQ12]
                end
            end
            TASE_ACC_ID_GROUP: begin
                if (lower && r.id_group != 2'd0 && hcfg_reg[r.id_group]) begin
                    l = TASE_LVL_HYP;  // [RQ8]
                end
            end
            TASE_ACC_DEBUG: begin
                if (r.cur_level != 2'd3 && mon_reg[0]) begin
                    l = TASE_LVL_MON;  // [RQ9]
                end
            end
            TASE_ACC_FINE_REG: begin
                if (FINE_GRAIN_EXT) begin
                    if (r.cur_level == 2'd2 && !mon_reg[1]) begin
                        l = TASE_LVL_MON;  // [RQ10]
                    end else if (lower && (r.is_read ? frd_reg[r.fine_index]
                                                     : fwr_reg[r.fine_index])) begin
                        l = TASE_LVL_HYP;  // [RQ11]
                    end
                end
            end
            default: l = TASE_LVL_NONE;
        endcase
        return l;
    endfunction

    // Error type for aborts; zero unless reliability ext and code 0x10
    function automatic logic [1:0] err_type(input tase_abort_type a);
        logic [1:0] e;
        e = 2'h0;
        if (RELIABILITY_EXT && a.fault_code == TASE_FC_SYNC_EXT) begin  // [RQ15]
            case (a.err_state)
                TASE_SET_UC:  e = TASE_SET_UC;
                TASE_SET_UEO: e = TASE_SET_UEO;
                default:      e = TASE_SET_UER;  // Reserved code folds to recoverable
            endcase
        end
        return e;  // [RQ16]
    endfunction

    // Syndrome build; monitor impdef wins, then abort, then trap
    always_comb begin
        tase_level_type tl;
        tl        = trap_level(sysreq);
        synd_next = '0;
        lvl_next  = TASE_LVL_NONE;
        take_next = 1'b0;
        if (impdef_in.valid) begin
            synd_next.exception_class = TASE_EC_IMPDEF;
            synd_next.syndrome_detail = impdef_in.detail;  // [RQ13]
            lvl_next  = TASE_LVL_MON;
            take_next = 1'b1;
        end else if (abort_in.valid) begin
            // Bits 24:13 and 8 stay zero [RQ14]
            synd_next.exception_class = abort_in.from_lower ? TASE_EC_IABT_LO
                                                            : TASE_EC_IABT_CUR;
            synd_next.syndrome_detail[TASE_SET_LO +: 2] = err_type(abort_in);
            // Address-invalid only for code 0x10 [RQ17] [RQ21]
            synd_next.syndrome_detail[TASE_FNV_BIT] =
                (abort_in.fault_code == TASE_FC_SYNC_EXT) && abort_in.addr_unknown;
            synd_next.syndrome_detail[TASE_EA_BIT] =
                abort_in.is_external && abort_in.ext_class;  // [RQ18]
            synd_next.syndrome_detail[TASE_STAGE1_WALK_FAULT_BIT] =
                abort_in.stage2 && abort_in.s1_walk;  // [RQ19]
            synd_next.syndrome_detail[5:0] = abort_in.fault_code;
            lvl_next  = abort_in.from_lower ? TASE_LVL_HYP : TASE_LVL_KERN;
            take_next = 1'b1;
        end else if (sysreq.valid && tl != TASE_LVL_NONE) begin
            synd_next.exception_class = TASE_EC_SYSREG;  // [RQ5]
            synd_next.syndrome_detail[TASE_OP0_LO +: 2] = sysreq.op0;  // [RQ20]
            synd_next.syndrome_detail[TASE_OP2_LO +: 3] = sysreq.op2;
            synd_next.syndrome_detail[TASE_OP1_LO +: 3] = sysreq.op1;
            synd_next.syndrome_detail[TASE_CRN_LO +: 4] = sysreq.major_sysreg_field;  // [RQ20]
            synd_next.syndrome_detail[TASE_RT_LO +: 5]  = sysreq.rt;   // [RQ1]
            synd_next.syndrome_detail[TASE_CRM_LO +: 4] = sysreq.minor_sysreg_field;  // [RQ2]
            synd_next.syndrome_detail[TASE_DIR_BIT]     = sysreq.is_read;  // [RQ3]
            lvl_next  = tl;
            take_next = 1'b1;
        end
    end

    // Syndrome store: no reset, so fields hold unknown until first exception [RQ4]
    always_ff @(posedge core_clk) begin
        if (take_next) begin
            synd_out <= synd_next;  // Class and detail together [RQ22]
        end
    end

    // Exception strobe and target level
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            exc_taken <= 1'b0;
            exc_level <= TASE_LVL_NONE;
            count_reg <= 8'h00;
        end else begin
            exc_taken <= take_next;
            if (take_next) begin
                exc_level <= lvl_next;
                count_reg <= count_reg + 8'h01;
            end
        end
    end

    // Read port, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                TASE_OFF_KCTL: reg_rdata <= kctl_reg;
                TASE_OFF_HCFG: reg_rdata <= hcfg_reg;
                TASE_OFF_MON:  reg_rdata <= mon_reg;
                TASE_OFF_FRD:  reg_rdata <= frd_reg;
                TASE_OFF_FWR:  reg_rdata <= fwr_reg;
                TASE_OFF_SYND: reg_rdata <= {1'b0, synd_out};
                TASE_OFF_STAT: reg_rdata <= {22'h0, exc_level, count_reg};
                default:       reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Checks
    a_sys_class: assert property (@(posedge core_clk) disable iff (!reset_n)
        take_next && !impdef_in.valid && !abort_in.valid |=>
        exc_taken && synd_out.exception_class == TASE_EC_SYSREG)  // [RQ5]
        else $error("trap class wrong");
    a_sys_fields: assert property (@(posedge core_clk) disable iff (!reset_n)
        take_next && !impdef_in.valid && !abort_in.valid |=>
        synd_out.syndrome_detail[9:5] == $past(sysreq.rt) &&
        synd_out.syndrome_detail[4:1] == $past(sysreq.minor_sysreg_field))  // [RQ1]
        else $error("rt or crm field wrong");
    a_sys_dir: assert property (@(posedge core_clk) disable iff (!reset_n)
        take_next && !impdef_in.valid && !abort_in.valid |=>
        synd_out.syndrome_detail[0] == $past(sysreq.is_read))  // [RQ3]
        else $error("direction bit wrong");
    a_sys_space: assert property (@(posedge core_clk) disable iff (!reset_n)
        take_next && !impdef_in.valid && !abort_in.valid |=>
        synd_out.syndrome_detail[21:20] == $past(sysreq.op0) &&
        synd_out.syndrome_detail[13:10] == $past(sysreq.major_sysreg_field))  // [RQ20]
        else $error("op0 or crn field wrong");
    a_tlb_trap: assert property (@(posedge core_clk) disable iff (!reset_n)
        sysreq.valid && !impdef_in.valid && !abort_in.valid &&
        sysreq.kind == TASE_ACC_TLB_MAINT && sysreq.cur_level < 2'd2 && hcfg_reg[0]
        |=> exc_taken && exc_level == TASE_LVL_HYP)  // [RQ7]
        else $error("tlb trap missed");
    a_dbg_trap: assert property (@(posedge core_clk) disable iff (!reset_n)
        sysreq.valid && !impdef_in.valid && !abort_in.valid &&
        sysreq.kind == TASE_ACC_DEBUG && sysreq.cur_level != 2'd3 && mon_reg[0]
        |=> exc_taken && exc_level == TASE_LVL_MON)  // [RQ9]
        else $error("debug trap missed");
    a_abt_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        abort_in.valid && !impdef_in.valid |=>
        synd_out.syndrome_detail[24:13] == 12'h000 && !synd_out.syndrome_detail[8])
        else $error("abort reserved bits set");  // [RQ14]
    a_abt_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        abort_in.valid && !impdef_in.valid && abort_in.fault_code != TASE_FC_SYNC_EXT
        |=> synd_out.syndrome_detail[12:10] == 3'h0)  // [RQ16]
        else $error("error type or fnv set for other code");
    a_abt_walk: assert property (@(posedge core_clk) disable iff (!reset_n)
        abort_in.valid && !impdef_in.valid && !abort_in.stage2
        |=> !synd_out.syndrome_detail[7])  // [RQ19]
        else $error("walk flag set on non stage 2 fault");
    a_abt_ea: assert property (@(posedge core_clk) disable iff (!reset_n)
        abort_in.valid && !impdef_in.valid && !abort_in.is_external
        |=> !synd_out.syndrome_detail[9])  // [RQ18]
        else $error("external class set on non external abort");
    a_impdef_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
        impdef_in.valid |=> synd_out.syndrome_detail == $past(impdef_in.detail)
        && exc_level == TASE_LVL_MON)  // [RQ13]
        else $error("impdef syndrome wrong");
    c_sys_trap: cover property (@(posedge core_clk) disable iff (!reset_n)
        exc_taken && synd_out.exception_class == TASE_EC_SYSREG);
    c_abort_ext: cover property (@(posedge core_clk) disable iff (!reset_n)
        exc_taken && synd_out.syndrome_detail[10]);
    c_fine_trap: cover property (@(posedge core_clk) disable iff (!reset_n)
        sysreq.valid && sysreq.kind == TASE_ACC_FINE_REG ##1 exc_taken);
    c_impdef: cover property (@(posedge core_clk) disable iff (!reset_n)
        impdef_in.valid ##1 exc_taken);
endmodule

// >>> dv/tase_pipe_model.sv
// Pipeline-side model: presents system accesses, aborts and impl-defined events.
// Assumes the bench calls fire() from its main sequence; outputs change only at edges.
`timescale 1ns/1ps
module tase_pipe_model
    import tase_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Event lines toward the encoder
    output tase_sysreq_type sysreq,
    output tase_abort_type  abort_in,
    output tase_impdef_type impdef_in
);
    // Idle payloads are scrambled so that stale fields never pass for valid ones
    task automatic idle_payload();
        tase_sysreq_type s;
        tase_abort_type  a;
        tase_impdef_type i;
        s = tase_sysreq_type'(36'({$urandom, $urandom}));
        a = tase_abort_type'(15'($urandom));
        i = tase_impdef_type'(26'($urandom));
        s.valid = 1'b0;
        a.valid = 1'b0;
        i.valid = 1'b0;
        sysreq    <= s;
        abort_in  <= a;
        impdef_in <= i;
    endtask

    // One event cycle, then release; costs a gap cycle but keeps drivers single
    task automatic fire(input tase_sysreq_type s, input tase_abort_type a,
                        input tase_impdef_type i);
        @(posedge core_clk);
        sysreq    <= s;
        abort_in  <= a;
        impdef_in <= i;
        @(posedge core_clk);
        idle_payload();
    endtask

    // Quiet lines at time zero
    initial begin
        sysreq    = '0;
        abort_in  = '0;
        impdef_in = '0;
    end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the trap and abort syndrome encoder.
// Assumes tase_pipe_model drives the event lines; the bench owns the register port.
`timescale 1ns/1ps
module tb_top;
    import tase_pkg::*;
    logic            core_clk;
    logic            reset_n;
    tase_sysreq_type sysreq;
    tase_abort_type  abort_in;
    tase_impdef_type impdef_in;
    logic [3:0]      reg_addr;
    logic [31:0]     reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [31:0]     reg_rdata;
    logic            exc_taken;
    tase_level_type  exc_level;
    tase_synd_type   synd_out;
    int              err_total;
    int              tests_run;
    logic [31:0]     cfg[5];      // Mirror of the writable registers
    tase_synd_type   m_synd;      // Model of the recorded syndrome
    logic [1:0]      m_level;
    logic [7:0]      m_count;
    logic            m_seen;      // Syndrome is unknown until the first exception

    tase_encoder tase_encoder_inst (.core_clk(core_clk), .reset_n(reset_n),
        .sysreq(sysreq), .abort_in(abort_in), .impdef_in(impdef_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .exc_taken(exc_taken), .exc_level(exc_level),
        .synd_out(synd_out));
    tase_pipe_model tase_pipe_model_inst (.core_clk(core_clk), .sysreq(sysreq),
        .abort_in(abort_in), .impdef_in(impdef_in));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Register port: one-cycle strobes, read data in the following cycle only
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a < 4'h5) cfg[a] = d;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check_val("reg_rdata", exp, reg_rdata);
    endtask

    // Reference model: {target level, class, detail}; level 0 means nothing taken
    function automatic logic [32:0] predict(tase_sysreq_type s, tase_abort_type a,
                                            tase_impdef_type i);
        logic [1:0]  t;
        logic [1:0]  lv;
        logic        sc;
        logic [1:0]  e;
        logic [24:0] d;
        t = 2'd0;
        lv = s.cur_level;
        if (i.valid) return {2'd3, TASE_EC_IMPDEF, i.detail};
        if (a.valid) begin
            sc = (a.fault_code == 6'h10);
            e = (sc && a.err_state != 2'b01) ? a.err_state : 2'b00;
            d = {12'h000, e, sc & a.addr_unknown, a.is_external & a.ext_class, 1'b0,
                 a.stage2 & a.s1_walk, 1'b0, a.fault_code};
            return a.from_lower ? {2'd2, TASE_EC_IABT_LO, d} : {2'd1, TASE_EC_IABT_CUR, d};
        end
        if (!s.valid) return 33'h0;
        if (s.kind <= TASE_ACC_TLB_MAINT && s.cache_ctl && cfg[1][4] && lv < 2)
            t = 2'd2;
        else if (s.kind <= TASE_ACC_INT_MASK) t = (lv == 0 && cfg[0][s.kind]) ? 2'd1 : 2'd0;
        else if (s.kind == TASE_ACC_TLB_MAINT) t = (lv < 2 && cfg[1][0]) ? 2'd2 : 2'd0;
        else if (s.kind == TASE_ACC_ID_GROUP) t = (lv < 2 && cfg[1][s.id_group]) ? 2'd2 : 2'd0;
        else if (s.kind == TASE_ACC_DEBUG) t = (lv < 3 && cfg[2][0]) ? 2'd3 : 2'd0;
        else t = (lv == 2 && !cfg[2][1]) ? 2'd3 : 2'd0;
        // Fine read/write trap bits only select accesses of the fine-register kind
        if (t == 0 && lv < 2 && s.kind == TASE_ACC_FINE_REG &&
            (s.is_read ? cfg[3][s.fine_index] : cfg[4][s.fine_index]))
            t = 2'd2;
        d = {3'b000, s.op0, s.op2, s.op1, s.major_sysreg_field, s.rt, s.minor_sysreg_field, s.is_read};
        return (t == 0) ? 33'h0 : {t, 6'h18, d};
    endfunction

    // One event through the partner, then result and the one-cycle pulse width
    task automatic send(input tase_sysreq_type s, input tase_abort_type a, input tase_impdef_type i);
        logic [32:0] p;
        p = predict(s, a, i);
        tase_pipe_model_inst.fire(s, a, i);
        #1 check_val("exc_taken", p[32:31] != 2'd0, exc_taken);
        if (p[32:31] != 2'd0) begin
            m_level = p[32:31];
            m_synd  = tase_synd_type'(p[30:0]);
            m_count = m_count + 8'h01;
            m_seen  = 1'b1;
        end
        check_val("exc_level", m_level, exc_level);
        if (m_seen) check_val("synd_out", m_synd, synd_out);
        @(posedge core_clk);
        #1 check_val("exc_taken", 0, exc_taken);
    endtask

    // Random event; mix selects which of sysreq, abort, impdef are valid
    task automatic rand_event(input logic [2:0] mix);
        tase_sysreq_type s;
        tase_abort_type  a;
        tase_impdef_type i;
        s = tase_sysreq_type'(36'({$urandom, $urandom}));
        a = tase_abort_type'(15'($urandom));
        i = tase_impdef_type'(26'($urandom));
        s.id_group = 2'(1 + $urandom_range(2));
        if (s.kind != TASE_ACC_CACHE_MAINT) s.cache_ctl = 1'b0;
        if ($urandom_range(1) == 1) a.fault_code = 6'h10;
        s.valid = mix[0];
        a.valid = mix[1];
        i.valid = mix[2];
        send(s, a, i);
    endtask

    // Hang guard
    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic sel;
        reset_n   = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        err_total = 0;
        tests_run = 0;
        cfg       = '{default: 32'h0000_0000};
        m_level   = 2'd0;
        m_count   = 8'h00;
        m_seen    = 1'b0;
        void'($urandom(32'h3c10418b));
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        // Controls and status start at zero; a hole reads zero
        for (int k = 0; k < 5; k++) reg_read(4'(k), 32'h0000_0000);
        reg_read(TASE_OFF_STAT, 32'h0000_0000);
        reg_read(4'hC, 32'h0000_0000);
        // Phase 0 arms only the monitor trap on hypervisor fine-register accesses, phase 7 arms that trap and the fine traps, others randomise all but the fine traps
        for (int ph = 0; ph < 8; ph++) begin
            sel = (ph > 0 && ph < 7);
            reg_write(TASE_OFF_KCTL, sel ? 32'($urandom_range(15)) : 32'h0000_0000);
            reg_write(TASE_OFF_HCFG, sel ? 32'($urandom_range(31)) : 32'h0000_0000);
            reg_write(TASE_OFF_MON, sel ? 32'($urandom_range(3)) : 32'h0000_0000);
            reg_write(TASE_OFF_FRD, (ph == 7) ? $urandom : 32'h0000_0000);
            reg_write(TASE_OFF_FWR, (ph == 7) ? $urandom : 32'h0000_0000);
            reg_read(TASE_OFF_FRD, cfg[3]);
            reg_read(TASE_OFF_FWR, cfg[4]);
            for (int n = 0; n < 60; n++)
                rand_event(($urandom_range(3) == 0) ? 3'($urandom_range(7)) : 3'b001);
            reg_read(TASE_OFF_STAT, {22'h0, m_level, m_count});
            if (m_seen) reg_read(TASE_OFF_SYND, {1'b0, m_synd});
        end
        // Read-only and unmapped writes change nothing
        reg_write(TASE_OFF_SYND, 32'hFFFF_FFFF);
        reg_write(TASE_OFF_STAT, 32'hFFFF_FFFF);
        reg_write(4'hB, 32'hFFFF_FFFF);
        reg_read(TASE_OFF_STAT, {22'h0, m_level, m_count});
        if (m_seen) reg_read(TASE_OFF_SYND, {1'b0, m_synd});
        reg_read(4'hB, 32'h0000_0000);
        // Reset in mid-run clears level, count and controls
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        cfg     = '{default: 32'h0000_0000};
        m_level = 2'd0;
        m_count = 8'h00;
        m_seen  = 1'b0;
        #1 check_val("exc_level", 0, exc_level);
        reg_read(TASE_OFF_STAT, 32'h0000_0000);
        reg_read(TASE_OFF_HCFG, 32'h0000_0000);
        repeat (8) rand_event(3'b001);
        rand_event(3'b110);
        report_and_stop();
    end
endmodule
